// >>> rtl/plink_regs.svh
// register map, field positions, reset values and timing counts of the parallel link
`ifndef PLINK_REGS_SVH
`define PLINK_REGS_SVH
// ************************************
// register byte offsets
// ************************************
`define A_CTRL 8'h00
`define A_TIMEOUT 8'h04
`define A_STATUS 8'h08
`define A_IRQ_STS 8'h0C
`define A_IRQ_CLR 8'h10
`define A_IRQ_EN 8'h14
`define R_OBITS 4'h2
`define R_IBITS 4'h8
`define R_OWORDS 2'h1
`define R_IWORDS 2'h3
// ************************************
// field positions and reset values
// ************************************
`define CTRL_W 5
`define IRQ_W 3
`define TIMEOUT_MS_RST 16'h01F4
`define NB_BITS 100
`define NB_SMALL 50
`define NB_WORDS 4'hA
// ************************************
// frame layout
// ************************************
`define HDR_REG 8'hA5
`define HDR_FAST 8'h5A
`define PAY_BYTES 6'h21
`define FAST_BYTES 6'h04
`define BIT_BYTES 6'h0D
// ************************************
// timing
// ************************************
`define CLK_HZ 125000000
`define BAUD_RATE 115200
`define BAUD_DIV (`CLK_HZ / `BAUD_RATE)
`define CLK_PER_MS (`CLK_HZ / 1000)
`endif

// >>> rtl/plink_pkg.sv
// types shared by the parallel link modules
package plink_pkg;
   typedef struct packed {
      logic narrow;
      logic fast;
      logic chan;
      logic slave;
      logic master;
   } cfg_t;
   typedef struct packed {
      logic vld;
      logic [7:0] data;
   } byte_t;
   typedef enum logic [1:0] {U_IDLE = 2'b00, U_START = 2'b01, U_DATA = 2'b10, U_STOP = 2'b11} uart_st_t;
   typedef enum logic [1:0] {RX_HDR = 2'b00, RX_PAY = 2'b01, RX_CKS = 2'b10} rx_st_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_WAIT = 2'b10} tx_st_t;
endpackage

// >>> rtl/plink_uart_tx.sv
// serial byte transmitter, 8 data bits, one stop bit
`timescale 1ns/1ps
`default_nettype none
`include "plink_regs.svh"
module plink_uart_tx (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire plink_pkg::byte_t i_byte,
   output logic o_ready,
   output logic o_txd
);
   import plink_pkg::*;
   localparam logic [15:0] DIV_M1 = 16'(`BAUD_DIV - 1);
   uart_st_t st_q;
   logic [15:0] div_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   assign o_ready = (st_q == U_IDLE);
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= U_IDLE;
         div_q <= 16'h0000;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         o_txd <= 1'b1;
      end else if (i_ce) begin
         if (st_q != U_IDLE && div_q != DIV_M1) begin
            div_q <= div_q + 16'h0001;
         end else begin
            div_q <= 16'h0000;
            case (st_q)
               U_IDLE: begin
                  if (i_byte.vld) begin
                     sh_q <= i_byte.data;
                     o_txd <= 1'b0;
                     st_q <= U_START;
                  end
               end
               U_START: begin
                  o_txd <= sh_q[0];
                  sh_q <= {1'b0, sh_q[7:1]};
                  bit_q <= 3'h0;
                  st_q <= U_DATA;
               end
               U_DATA: begin
                  if (bit_q == 3'h7) begin
                     o_txd <= 1'b1;
                     st_q <= U_STOP;
                  end else begin
                     o_txd <= sh_q[0];
                     sh_q <= {1'b0, sh_q[7:1]};
                     bit_q <= bit_q + 3'h1;
                  end
               end
               default: st_q <= U_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/plink_uart_rx.sv
// serial byte receiver, samples each bit at its centre
`timescale 1ns/1ps
`default_nettype none
`include "plink_regs.svh"
module plink_uart_rx (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_rxd,
   output plink_pkg::byte_t o_byte
);
   import plink_pkg::*;
   localparam logic [15:0] DIV_M1 = 16'(`BAUD_DIV - 1);
   localparam logic [15:0] HALF = 16'(`BAUD_DIV / 2);
   uart_st_t st_q;
   logic [15:0] div_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= U_IDLE;
         div_q <= 16'h0000;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         o_byte <= '0;
      end else if (i_ce) begin
         o_byte.vld <= 1'b0;
         div_q <= div_q + 16'h0001;
         case (st_q)
            U_IDLE: begin
               div_q <= 16'h0000;
               if (!i_rxd) begin
                  st_q <= U_START;
               end
            end
            U_START: begin
               if (div_q == HALF) begin
                  div_q <= 16'h0000;
                  bit_q <= 3'h0;
                  st_q <= i_rxd ? U_IDLE : U_DATA;
               end
            end
            U_DATA: begin
               if (div_q == DIV_M1) begin
                  div_q <= 16'h0000;
                  sh_q <= {i_rxd, sh_q[7:1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     st_q <= U_STOP;
                  end
               end
            end
            default: begin
               if (div_q == DIV_M1) begin
                  st_q <= U_IDLE;
                  o_byte.vld <= i_rxd;
                  o_byte.data <= sh_q;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> rtl/two_station_parallel_link.sv
// parallel link station: frame exchange, supervision and ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "plink_regs.svh"
// Notes on behaviour
// - with only the master select bit on the station polls the peer as master.
// - with only the slave select bit on the station answers the peer as slave.
// - the link uses channel 1 pins while the channel select bit is off, channel 2 while on.
// - the error timeout is held in milliseconds and resets to 500.
// - the link active flag stays on for as long as the link is operating.
// - the role error flag is on when both role bits are set together.
// - the communication error flag is raised whenever the link fails.
// - the master sends 100 bits and 10 words, or 50 bits and 10 words when small.
// - the slave sends 100 bits and 10 words, or 50 bits and 10 words when small.
// - both stations must use the same mode; a header of the other mode is never accepted.
// - new settings take effect only at a stop to run change or at power up.
// - the indicators toggle with traffic and are held off while the link is inactive or has a communication error.
// - two modes exist, regular and high speed, each with its own payload.
// - with the fast mode bit on only 2 words go each way.
// - after a link error the received copies keep their last good values.
module two_station_parallel_link #(
   parameter int CYCLES_PER_MS = `CLK_PER_MS
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_run,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   input wire logic i_ch1_rxd,
   input wire logic i_ch2_rxd,
   output logic o_ch1_txd,
   output logic o_ch2_txd,
   output logic o_transmit_indicator,
   output logic o_receive_indicator,
   output logic o_irq
);
   import plink_pkg::*;
   localparam logic [19:0] PRE_M1 = 20'(CYCLES_PER_MS - 1);

   cfg_t ctrl_q;
   cfg_t act_q;
   logic [15:0] tmo_ms_q;
   logic [15:0] act_tmo_q;
   logic [3:0][31:0] obits_q;
   logic [9:0][15:0] owords_q;
   logic [127:0] ibits_q;
   logic [9:0][15:0] iwords_q;
   logic [32:0][7:0] sh_q;
   logic [127:0] mask_full;
   logic [127:0] mask_act;
   logic [127:0] obits_m;
   logic [32:0][7:0] tx_pl;
   logic [2:0] ists_q;
   logic [2:0] ists_d;
   logic [2:0] ien_q;
   logic [2:0] ev;
   logic ap_we_q;
   logic [7:0] ap_addr_q;
   logic acc;
   logic [31:0] rd_data;
   logic run_q;
   logic apply;
   logic link_act_q;
   logic role_err_q;
   logic comm_err_q;
   logic is_master;
   logic [1:0] rxs1_q;
   logic [1:0] rxs2_q;
   logic rx_line;
   logic tx_line;
   logic [5:0] n_pay;
   logic [5:0] off;
   logic [7:0] hdr;
   tx_st_t tx_st_q;
   logic [5:0] tx_idx_q;
   logic [7:0] tx_cks_q;
   byte_t tx_byte;
   logic tx_rdy;
   logic tx_acc;
   rx_st_t rx_st_q;
   logic [5:0] rx_idx_q;
   logic [7:0] rx_cks_q;
   byte_t rx_byte;
   logic good_q;
   logic exp_q;
   logic [19:0] pre_q;
   logic [15:0] wd_ms_q;

   // ************************************
   // bit masks per mode
   // ************************************
   for (genvar i = 0; i < 128; i++) begin : g_mask
      assign mask_full[i] = (i < `NB_BITS);
      assign mask_act[i] = (i < (act_q.narrow ? `NB_SMALL : `NB_BITS));
   end
   assign obits_m = obits_q & mask_act;
   assign tx_pl = {owords_q, obits_m[103:0]};
   assign is_master = act_q.master & ~act_q.slave;
   assign n_pay = act_q.fast ? `FAST_BYTES : `PAY_BYTES;
   assign off = act_q.fast ? `BIT_BYTES : 6'h00;
   assign hdr = act_q.fast ? `HDR_FAST : `HDR_REG;

   // ************************************
   // ahb-lite slave
   // ************************************
   assign acc = i_hsel & i_hready & i_htrans[1];
   always_comb begin
      rd_data = 32'h0000_0000;
      if (i_haddr[7:0] == `A_CTRL) begin
         rd_data[`CTRL_W-1:0] = ctrl_q;
      end else if (i_haddr[7:0] == `A_TIMEOUT) begin
         rd_data[15:0] = tmo_ms_q;
      end else if (i_haddr[7:0] == `A_STATUS) begin
         rd_data[3:0] = {is_master, comm_err_q, role_err_q, link_act_q};
      end else if (i_haddr[7:0] == `A_IRQ_STS) begin
         rd_data[`IRQ_W-1:0] = ists_q;
      end else if (i_haddr[7:0] == `A_IRQ_EN) begin
         rd_data[`IRQ_W-1:0] = ien_q;
      end else if (i_haddr[7:4] == `R_OBITS) begin
         rd_data = obits_q[i_haddr[3:2]] & mask_full[32*i_haddr[3:2] +: 32];
      end else if (i_haddr[7:4] == `R_IBITS) begin
         rd_data = ibits_q[32*i_haddr[3:2] +: 32];
      end else if (i_haddr[7:6] == `R_OWORDS && i_haddr[5:2] < `NB_WORDS) begin
         rd_data[15:0] = owords_q[i_haddr[5:2]];
      end else if (i_haddr[7:6] == `R_IWORDS && i_haddr[5:2] < `NB_WORDS) begin
         rd_data[15:0] = iwords_q[i_haddr[5:2]];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h0000_0000;
         ap_we_q <= 1'b0;
         ap_addr_q <= 8'h00;
      end else if (i_ce) begin
         ap_we_q <= acc & i_hwrite;
         ap_addr_q <= i_haddr[7:0];
         if (acc && !i_hwrite) begin
            o_hrdata <= rd_data;
         end
      end
   end

   // register writes in the data phase
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q <= '0;
         tmo_ms_q <= `TIMEOUT_MS_RST;
         ien_q <= '0;
         obits_q <= '0;
         owords_q <= '0;
      end else if (i_ce && ap_we_q) begin
         if (ap_addr_q == `A_CTRL) begin
            ctrl_q <= cfg_t'(i_hwdata[`CTRL_W-1:0]);
         end
         if (ap_addr_q == `A_TIMEOUT) begin
            tmo_ms_q <= i_hwdata[15:0];
         end
         if (ap_addr_q == `A_IRQ_EN) begin
            ien_q <= i_hwdata[`IRQ_W-1:0];
         end
         if (ap_addr_q[7:4] == `R_OBITS) begin
            obits_q[ap_addr_q[3:2]] <= i_hwdata;
         end
         if (ap_addr_q[7:6] == `R_OWORDS && ap_addr_q[5:2] < `NB_WORDS) begin
            owords_q[ap_addr_q[5:2]] <= i_hwdata[15:0];
         end
      end
   end

   // ************************************
   // settings, role and link state
   // ************************************
   assign apply = i_run & ~run_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         run_q <= 1'b0;
         act_q <= '0;
         act_tmo_q <= `TIMEOUT_MS_RST;
         role_err_q <= 1'b0;
         link_act_q <= 1'b0;
      end else if (i_ce) begin
         run_q <= i_run;
         if (apply) begin
            act_q <= ctrl_q;
            act_tmo_q <= tmo_ms_q;
            role_err_q <= ctrl_q.master & ctrl_q.slave;
         end
         link_act_q <= i_run & (act_q.master ^ act_q.slave);
      end
   end

   // ************************************
   // pins and channel select
   // ************************************
   assign rx_line = act_q.chan ? rxs2_q[1] : rxs2_q[0];
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rxs1_q <= 2'h3;
         rxs2_q <= 2'h3;
         o_ch1_txd <= 1'b1;
         o_ch2_txd <= 1'b1;
      end else if (i_ce) begin
         rxs1_q <= {i_ch2_rxd, i_ch1_rxd};
         rxs2_q <= rxs1_q;
         o_ch1_txd <= act_q.chan ? 1'b1 : tx_line;
         o_ch2_txd <= act_q.chan ? tx_line : 1'b1;
      end
   end

   plink_uart_tx u_tx (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_byte(tx_byte),
      .o_ready(tx_rdy),
      .o_txd(tx_line)
   );

   plink_uart_rx u_rx (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_rxd(rx_line),
      .o_byte(rx_byte)
   );

   // ************************************
   // frame transmitter
   // ************************************
   always_comb begin
      tx_byte.vld = (tx_st_q == TX_SEND);
      if (tx_idx_q == 6'h00) begin
         tx_byte.data = hdr;
      end else if (tx_idx_q <= n_pay) begin
         tx_byte.data = tx_pl[tx_idx_q - 6'h01 + off];
      end else begin
         tx_byte.data = tx_cks_q;
      end
   end
   assign tx_acc = tx_byte.vld & tx_rdy;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_st_q <= TX_IDLE;
         tx_idx_q <= 6'h00;
         tx_cks_q <= 8'h00;
      end else if (i_ce) begin
         if (!link_act_q) begin
            tx_st_q <= TX_IDLE;
         end else begin
            case (tx_st_q)
               TX_IDLE: begin
                  tx_idx_q <= 6'h00;
                  if (is_master || good_q) begin
                     tx_st_q <= TX_SEND;
                  end
               end
               TX_SEND: begin
                  if (tx_acc) begin
                     tx_cks_q <= (tx_idx_q == 6'h00) ? tx_byte.data : tx_cks_q ^ tx_byte.data;
                     tx_idx_q <= tx_idx_q + 6'h01;
                     if (tx_idx_q == n_pay + 6'h01) begin
                        tx_st_q <= is_master ? TX_WAIT : TX_IDLE;
                     end
                  end
               end
               TX_WAIT: begin
                  if (good_q || exp_q) begin
                     tx_st_q <= TX_IDLE;
                  end
               end
               default: tx_st_q <= TX_IDLE;
            endcase
         end
      end
   end

   // ************************************
   // frame receiver
   // ************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_st_q <= RX_HDR;
         rx_idx_q <= 6'h00;
         rx_cks_q <= 8'h00;
         good_q <= 1'b0;
      end else if (i_ce) begin
         good_q <= 1'b0;
         if (!link_act_q || exp_q) begin
            rx_st_q <= RX_HDR;
         end else if (rx_byte.vld) begin
            case (rx_st_q)
               RX_HDR: begin
                  rx_idx_q <= 6'h00;
                  rx_cks_q <= rx_byte.data;
                  if (rx_byte.data == hdr) begin
                     rx_st_q <= RX_PAY;
                  end
               end
               RX_PAY: begin
                  rx_cks_q <= rx_cks_q ^ rx_byte.data;
                  rx_idx_q <= rx_idx_q + 6'h01;
                  if (rx_idx_q == n_pay - 6'h01) begin
                     rx_st_q <= RX_CKS;
                  end
               end
               RX_CKS: begin
                  rx_st_q <= RX_HDR;
                  good_q <= (rx_byte.data == rx_cks_q);
               end
               default: rx_st_q <= RX_HDR;
            endcase
         end
      end
   end

   // incoming payload shadow
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sh_q <= '0;
      end else if (i_ce && rx_byte.vld && rx_st_q == RX_PAY) begin
         sh_q[rx_idx_q + off] <= rx_byte.data;
      end
   end

   // received copies change only on a good frame
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ibits_q <= '0;
         iwords_q <= '0;
      end else if (i_ce && good_q && link_act_q) begin
         if (act_q.fast) begin
            iwords_q[1:0] <= sh_q[16:13];
         end else begin
            ibits_q <= {24'h00_0000, sh_q[12:0]} & mask_act;
            iwords_q <= sh_q[32:13];
         end
      end
   end

   // ************************************
   // supervision timer and error flag
   // ************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_q <= 20'h0_0000;
         wd_ms_q <= 16'h0000;
         exp_q <= 1'b0;
      end else if (i_ce) begin
         exp_q <= 1'b0;
         if (!link_act_q || good_q) begin
            pre_q <= 20'h0_0000;
            wd_ms_q <= 16'h0000;
         end else if (pre_q == PRE_M1) begin
            pre_q <= 20'h0_0000;
            if (wd_ms_q + 16'h0001 >= act_tmo_q) begin
               wd_ms_q <= 16'h0000;
               exp_q <= 1'b1;
            end else begin
               wd_ms_q <= wd_ms_q + 16'h0001;
            end
         end else begin
            pre_q <= pre_q + 20'h0_0001;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         comm_err_q <= 1'b0;
      end else if (i_ce) begin
         if (exp_q) begin
            comm_err_q <= 1'b1;
         end else if (good_q || apply) begin
            comm_err_q <= 1'b0;
         end
      end
   end

   // ************************************
   // indicators
   // ************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_transmit_indicator <= 1'b0;
         o_receive_indicator <= 1'b0;
      end else if (i_ce) begin
         if (!link_act_q || comm_err_q) begin
            o_transmit_indicator <= 1'b0;
            o_receive_indicator <= 1'b0;
         end else begin
            o_transmit_indicator <= o_transmit_indicator ^ tx_acc;
            o_receive_indicator <= o_receive_indicator ^ rx_byte.vld;
         end
      end
   end

   // ************************************
   // interrupts
   // ************************************
   assign ev = {apply & ctrl_q.master & ctrl_q.slave, exp_q, good_q};
   always_comb begin
      ists_d = ists_q;
      if (ap_we_q && ap_addr_q == `A_IRQ_CLR) begin
         ists_d = ists_q & ~i_hwdata[`IRQ_W-1:0];
      end
      ists_d = ists_d | ev;
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ists_q <= '0;
         o_irq <= 1'b0;
      end else if (i_ce) begin
         ists_q <= ists_d;
         o_irq <= |(ists_d & ien_q);
      end
   end
endmodule
`default_nettype wire

// >>> bench/plink_peer.sv
// peer station model driving the serial receive line of the link
`timescale 1ns/1ps
`default_nettype none
`include "plink_regs.svh"
module plink_peer (
   input wire logic i_sys_clk,
   output logic o_txd
);
   initial o_txd = 1'b1;
   // one 8n1 byte, lsb first, then gap idle bit times
   task automatic send_byte(input logic [7:0] b, input int gap);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10 + gap; i++) begin
         o_txd <= (i < 10) ? sh[i] : 1'b1;
         repeat (`BAUD_DIV) @(posedge i_sys_clk);
      end
   endtask
   // fast frame: header, two words little endian, xor checksum
   task automatic send_fast(input logic [15:0] w0, input logic [15:0] w1, input int gap);
      logic [47:0] f;
      f = {8'h00, w1, w0, `HDR_FAST};
      f[47:40] = f[7:0] ^ f[15:8] ^ f[23:16] ^ f[31:24] ^ f[39:32];
      for (int i = 0; i < 6; i++) begin
         send_byte(f[8*i +: 8], gap);
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/plink_checker_assertions.sv
// concurrent checks on the parallel link station ports
`timescale 1ns/1ps
`default_nettype none
module plink_checker (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic o_hreadyout,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hresp,
   input wire logic o_ch1_txd,
   input wire logic o_ch2_txd,
   input wire logic o_transmit_indicator,
   input wire logic o_receive_indicator,
   input wire logic o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // write of zero into the interrupt enable register
   sequence en_addr;
      i_hsel && o_hreadyout && i_htrans[1] && i_hwrite && i_haddr[7:0] == 8'h14;
   endsequence
   sequence mask_off;
      en_addr ##1 i_hwdata == 32'h0000_0000;
   endsequence
   zero_wait_a: assert property (o_hreadyout) else $error("wait state seen");
   okay_resp_a: assert property (!o_hresp) else $error("error response seen");
   rdata_hold_a: assert property (!(i_hsel && o_hreadyout && i_htrans[1] && !i_hwrite)
      |=> $stable(o_hrdata)) else $error("read data moved");
   one_chan_a: assert property (o_ch1_txd || o_ch2_txd)
      else $error("both channels active");
   start_bit_a: assert property ($fell(o_ch1_txd) |=> !o_ch1_txd [*8])
      else $error("short serial bit");
   rx_ind_a: assert property ($changed(o_receive_indicator)
      |=> $stable(o_receive_indicator) [*8]) else $error("receive lamp flicker");
   ind_idle_a: assert property (!i_run [*3]
      |-> !o_transmit_indicator && !o_receive_indicator) else $error("lamp on while idle");
   irq_mask_a: assert property (mask_off |-> ##2 !o_irq)
      else $error("irq high while masked");
endmodule
bind two_station_parallel_link plink_checker chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_run(i_run), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .o_hreadyout(o_hreadyout),
   .o_hrdata(o_hrdata), .o_hresp(o_hresp), .o_ch1_txd(o_ch1_txd), .o_ch2_txd(o_ch2_txd),
   .o_transmit_indicator(o_transmit_indicator),
   .o_receive_indicator(o_receive_indicator), .o_irq(o_irq));
`default_nettype wire

// >>> bench/test_two_station_parallel_link.sv
// self-checking testbench of the parallel link station
`timescale 1ns/1ps
`default_nettype none
`include "plink_regs.svh"
module test_two_station_parallel_link;
   logic clk, rst, run, hsel, hwrite, rxd, rdy, resp, txd1, txd2, tx_ind, rx_ind, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [7:0] hdr;
   int err_total = 0;
   int n_tests = 0;
   two_station_parallel_link #(.CYCLES_PER_MS(10)) uut (.i_sys_clk(clk), .i_rst(rst),
      .i_ce(1'b1), .i_run(run), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(rdy),
      .o_hreadyout(rdy), .o_hrdata(hrdata), .o_hresp(resp), .i_ch1_rxd(rxd),
      .i_ch2_rxd(txd1), .o_ch1_txd(txd1), .o_ch2_txd(txd2),
      .o_transmit_indicator(tx_ind), .o_receive_indicator(rx_ind), .o_irq(irq));
   plink_peer peer (.i_sys_clk(clk), .o_txd(rxd));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(n, e, q);
   endtask
   task automatic apply(input logic [31:0] c, input logic [31:0] t);
      run <= 1'b0;
      wr(`A_CTRL, c);
      wr(`A_TIMEOUT, t);
      run <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic get_byte(output logic [7:0] b);
      @(negedge txd1);
      repeat (`BAUD_DIV * 3 / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = txd1;
         repeat (`BAUD_DIV) @(posedge clk);
      end
   endtask
   task automatic t_regs();
      rdc("ctrl", `A_CTRL, 32'h0000_0000);
      rdc("timeout", `A_TIMEOUT, 32'h0000_01F4);
      rdc("status", `A_STATUS, 32'h0000_0000);
      wr(8'h18, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h18, 32'h0000_0000);
      wr(8'h40, 32'h0000_1234);
      rdc("out word", 8'h40, 32'h0000_1234);
      $display("regs done");
   endtask
   task automatic t_role();
      wr(`A_IRQ_EN, 32'h0000_0007);
      apply(32'h0000_0003, 32'h0000_01F4);
      rdc("role status", `A_STATUS, 32'h0000_0002);
      chk("irq", 1, irq);
      rdc("irq status", `A_IRQ_STS, 32'h0000_0004);
      wr(`A_IRQ_CLR, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk("irq cleared", 0, irq);
      $display("role done");
   endtask
   task automatic t_timeout();
      apply(32'h0000_0002, 32'h0000_01F4);
      rdc("slave status", `A_STATUS, 32'h0000_0001);
      apply(32'h0000_0001, 32'h0000_0001);
      repeat (40) @(posedge clk);
      rdc("master status", `A_STATUS, 32'h0000_000D);
      chk("irq", 1, irq);
      rdc("irq status", `A_IRQ_STS, 32'h0000_0002);
      rdc("in word", 8'hC0, 32'h0000_0000);
      wr(`A_CTRL, 32'h0000_0002);
      rdc("late ctrl", `A_STATUS, 32'h0000_000D);
      wr(`A_IRQ_EN, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk("irq masked", 0, irq);
      run <= 1'b0;
      repeat (11000) @(posedge clk);
      $display("timeout done");
   endtask
   task automatic t_frame();
      wr(`A_IRQ_CLR, 32'h0000_0007);
      wr(`A_IRQ_EN, 32'h0000_0001);
      wr(`A_CTRL, 32'h0000_0009);
      wr(`A_TIMEOUT, 32'h0000_2000);
      fork
         begin
            run <= 1'b1;
            get_byte(hdr);
            chk("ch2 idle", 1, txd2);
         end
         begin
            repeat (`BAUD_DIV) @(posedge clk);
            peer.send_fast(16'h1234, 16'hBEEF, 1);
         end
      join
      repeat (20) @(posedge clk);
      chk("header", {24'h00_0000, `HDR_FAST}, {24'h00_0000, hdr});
      rdc("in word 0", 8'hC0, 32'h0000_1234);
      rdc("in word 1", 8'hC4, 32'h0000_BEEF);
      rdc("link status", `A_STATUS, 32'h0000_0009);
      chk("frame irq", 1, irq);
      apply(32'h0000_0009, 32'h0000_0001);
      repeat (40) @(posedge clk);
      rdc("error status", `A_STATUS, 32'h0000_000D);
      rdc("frozen word", 8'hC4, 32'h0000_BEEF);
      $display("frame done");
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      err_total++;
      $display("watchdog expired");
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      run = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_role();
      t_timeout();
      t_frame();
      give_verdict();
   end
endmodule
`default_nettype wire
